/* File: inc/adc_readout_pkg.sv */
// Constants and types shared by the converter readout and mode control.
// Assumes every clock count is in master clocks, one master clock per CLK_I cycle.
package adc_readout_pkg;

	// Conversion cycle framing, in master clocks.
	localparam logic [8:0] CONV_CLKS = 9'h180;
	localparam logic [8:0] LOW_CLKS = 9'h006;
	localparam logic [8:0] HIGH_CLKS = 9'h006;
	localparam logic [8:0] TAIL_CLKS = 9'h018;
	localparam logic [8:0] READY_END = LOW_CLKS + HIGH_CLKS;
	localparam logic [8:0] DATA_END = CONV_CLKS - TAIL_CLKS;
	localparam logic [8:0] LAST_POS = CONV_CLKS - 9'h001;

	// Result word width and the bit counter ceiling.
	localparam int RESULT_BITS = 24;
	localparam logic [4:0] RESULT_BITS_CNT = 5'h18;

	// Held-high detection and the low pulse that marks it.
	localparam logic [2:0] SYNC_CYCLES = 3'h4;
	localparam logic [1:0] SYNC_PULSE_CLKS = 2'h3;

	// Times given in half master clocks, and the counts derived from them.
	localparam int SYNC_WAKE_HALF = 4085;
	localparam int PD_WAKE_HALF = 4637;
	localparam int MUX_WAKE_HALF = 4087;
	localparam int PD_HOLD_HALF = 12289;
	localparam logic [11:0] SYNC_WAKE_CLKS = 12'((SYNC_WAKE_HALF + 1) / 2);
	localparam logic [11:0] PD_WAKE_CLKS = 12'((PD_WAKE_HALF + 1) / 2);
	localparam logic [11:0] MUX_WAKE_CLKS = 12'((MUX_WAKE_HALF + 1) / 2);
	localparam int PD_HOLD_CLKS = PD_HOLD_HALF / 2;

	// Operating modes of the readout.
	typedef enum logic [2:0] {
		S_RUN,
		S_SYNC,
		S_HELD,
		S_PD,
		S_WAKE
	} mode_t;

	// Status flags that leave the block together.
	typedef struct packed {
		logic power_down;
		logic mod_reset;
	} status_t;

	localparam status_t STATUS_RESET = 2'h0;

endpackage

/* File: core/adc_readout.sv */
// Readout framing, serial shift-out and held-clock sync/power-down control.
// Assumes the serial clock and channel selects arrive from pins, while the
// 24-bit result comes from the filter on CLK_I, which is the master clock.
`timescale 1ns/1ps

module adc_readout
	import adc_readout_pkg::*;
#(
	parameter int PD_HOLD = PD_HOLD_CLKS
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic SCLK_I,
	input wire logic CHANNEL_SELECT_BIT0_I,
	input wire logic CHANNEL_SELECT_BIT1_I,
	input wire logic [RESULT_BITS-1:0] RESULT_I,
	output logic READY_DATA_LINE_O,
	output status_t STATUS_O
);

	localparam logic [12:0] PD_HOLD_LAST = 13'(PD_HOLD - 1);

	logic sclk_meta;
	logic sclk_s;
	logic sclk_d;
	logic [1:0] chsel_meta;
	logic [1:0] chsel_s;
	logic [1:0] chsel_d;
	logic sclk_fall;
	logic chsel_change;
	mode_t state;
	logic [8:0] pos;
	logic [1:0] pulse_cnt;
	logic [12:0] hold_cnt;
	logic [11:0] wake_cnt;
	logic [11:0] pd_wake_age; // Clocks since leaving power-down, for checks.
	logic [2:0] high_cycles;
	logic low_seen;
	logic [RESULT_BITS-1:0] result_shift_register;
	logic [4:0] bit_cnt;
	logic next_line;

	// True while the line carries result bits.
	function automatic logic in_data(input logic [8:0] p);
		in_data = (p >= READY_END) && (p < DATA_END);
	endfunction

	// Two-stage synchronisers for pin inputs; the first stage feeds only the
	// second, so metastability never reaches the edge detectors.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			sclk_meta <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			chsel_meta <= 2'h0;
			chsel_s <= 2'h0;
			chsel_d <= 2'h0;
		end else if (CE_I) begin
			sclk_meta <= SCLK_I;
			sclk_s <= sclk_meta;
			sclk_d <= sclk_s;
			chsel_meta <= {CHANNEL_SELECT_BIT1_I, CHANNEL_SELECT_BIT0_I};
			chsel_s <= chsel_meta;
			chsel_d <= chsel_s;
		end
	end

	// Edge events taken from the synchronised copies only.
	assign sclk_fall = sclk_d && !sclk_s;
	assign chsel_change = chsel_d != chsel_s;

	// Mode sequencing and the conversion position counter.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state <= S_RUN;
			pos <= 9'h000;
			pulse_cnt <= 2'h0;
			hold_cnt <= 13'h0000;
			wake_cnt <= 12'h000;
			pd_wake_age <= 12'h000;
		end else if (CE_I) begin
			case (state)
				S_RUN: begin
					pd_wake_age <= 12'h000;
					if (pos == LAST_POS && !low_seen && sclk_s &&
					    high_cycles == SYNC_CYCLES - 3'h1) begin
						state <= S_SYNC;
						pulse_cnt <= 2'h0;
					end else if (chsel_change) begin
						state <= S_WAKE;
						wake_cnt <= MUX_WAKE_CLKS;
					end else if (pos == LAST_POS) begin
						pos <= 9'h000;
					end else begin
						pos <= pos + 9'h001;
					end
				end
				S_SYNC: begin
					if (pulse_cnt == SYNC_PULSE_CLKS - 2'h1) begin
						state <= S_HELD;
						hold_cnt <= 13'h0000;
					end else begin
						pulse_cnt <= pulse_cnt + 2'h1;
					end
				end
				S_HELD: begin
					if (sclk_fall) begin
						state <= S_WAKE;
						wake_cnt <= SYNC_WAKE_CLKS;
					end else if (hold_cnt == PD_HOLD_LAST) begin
						state <= S_PD;
					end else begin
						hold_cnt <= hold_cnt + 13'h0001;
					end
				end
				S_PD: begin
					if (sclk_fall) begin
						state <= S_WAKE;
						wake_cnt <= PD_WAKE_CLKS;
						pd_wake_age <= 12'h001;
					end
				end
				S_WAKE: begin
					// The first pulse after waking carries settled data.
					if (wake_cnt <= 12'h001) begin
						state <= S_RUN;
						pos <= 9'h000;
					end else begin
						wake_cnt <= wake_cnt - 12'h001;
						pd_wake_age <= pd_wake_age +
						    {11'h000, pd_wake_age != 12'h000};
					end
				end
				default: begin
					state <= S_RUN;
					pos <= 9'h000;
				end
			endcase
		end
	end

	// Held-high cycle counter; any low sample in a cycle restarts it, since
	// an idle host is expected to park the clock low.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			high_cycles <= 3'h0;
			low_seen <= 1'b0;
		end else if (CE_I) begin
			if (state != S_RUN) begin
				high_cycles <= 3'h0;
				low_seen <= 1'b0;
			end else if (pos == LAST_POS) begin
				low_seen <= 1'b0;
				if (low_seen || !sclk_s) begin
					high_cycles <= 3'h0;
				end else if (high_cycles != SYNC_CYCLES) begin
					high_cycles <= high_cycles + 3'h1;
				end
			end else if (!sclk_s) begin
				low_seen <= 1'b1;
			end
		end
	end

	// Result shifter: loaded at the start of every cycle, so a late reader
	// gets the new word, not the tail of the old one.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			result_shift_register <= '0;
			bit_cnt <= 5'h00;
		end else if (CE_I) begin
			if (state == S_RUN && pos == 9'h000) begin
				// Two's-complement word passes through unchanged.
				result_shift_register <= RESULT_I;
				bit_cnt <= 5'h00;
			end else if (state == S_RUN && in_data(pos) && sclk_fall) begin
				// Zeros shift in behind the LSB for surplus clocks.
				result_shift_register <=
				    {result_shift_register[RESULT_BITS-2:0], 1'b0};
				if (bit_cnt != RESULT_BITS_CNT) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end

	// Line level chosen from mode and position.
	always_comb begin
		next_line = 1'b1;
		case (state)
			S_RUN: begin
				if (pos < LOW_CLKS) begin
					next_line = 1'b0;
				end else if (in_data(pos)) begin
					next_line = result_shift_register[RESULT_BITS-1];
				end else begin
					next_line = 1'b1;
				end
			end
			S_SYNC: next_line = 1'b0;
			default: next_line = 1'b1;
		endcase
	end

	// Registered outputs.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			READY_DATA_LINE_O <= 1'b1;
			STATUS_O <= STATUS_RESET;
		end else if (CE_I) begin
			READY_DATA_LINE_O <= next_line;
			STATUS_O.mod_reset <= state == S_HELD || state == S_PD;
			STATUS_O.power_down <= state == S_PD;
		end
	end

	sequence seq_ready_pulse;
		!READY_DATA_LINE_O [*6] ##1 READY_DATA_LINE_O [*6];
	endsequence

	sequence seq_sync_pulse;
		!READY_DATA_LINE_O [*3] ##1 READY_DATA_LINE_O;
	endsequence

	a_ready_pulse_shape: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_RUN && pos == 9'h000 && !chsel_change) |=> seq_ready_pulse)
	else $error("ready pulse shape wrong");

	a_sync_low_pulse: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    $rose(state == S_SYNC) |=> seq_sync_pulse)
	else $error("sync pulse not three clocks low");

	a_tail_held_high: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_RUN && pos >= DATA_END) |=> READY_DATA_LINE_O)
	else $error("tail interval not high");

	a_held_enter_pd: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_HELD && hold_cnt == PD_HOLD_LAST && !sclk_fall)
	    |=> ##1 STATUS_O.power_down)
	else $error("power-down not entered after hold");

	a_pd_wake_fall: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_PD && sclk_fall) |=> ##1 !STATUS_O.power_down)
	else $error("power-down not left on falling edge");

	a_held_mod_reset: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    $rose(state == S_HELD) |=> STATUS_O.mod_reset && !STATUS_O.power_down)
	else $error("modulator not held in reset");

	a_extra_clocks_low: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_RUN && in_data(pos) && bit_cnt == RESULT_BITS_CNT)
	    |=> !READY_DATA_LINE_O)
	else $error("line not low after surplus clocks");

	a_high_count_clear: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_RUN && pos == LAST_POS && !sclk_s) |=> high_cycles == 3'h0)
	else $error("high cycle count not cleared");

	a_wake_first_ready: assert property (@(posedge CLK_I)
	    disable iff (!RST_N_I || !CE_I)
	    (state == S_RUN && pd_wake_age != 12'h000) |->
	    pd_wake_age inside {[PD_WAKE_CLKS - 12'h001:PD_WAKE_CLKS + 12'h001]})
	else $error("first ready after wake mistimed");

endmodule

/* File: tb/host_reader.sv */
// Host model that makes the serial clock and gathers the result bits.
// Assumes the converter changes bits on serial clock falls.
`timescale 1ns/1ps
module host_reader (
	output logic sclk_o,
	input wire logic line_i
);
	// The clock stands low outside frames.
	initial begin
		sclk_o = 1'b0;
	end

	// Short high and long low phases, since each fall needs a few master
	// clocks to reach the line. A frame ends well before the next ready.
	task automatic read_word(input int n, output logic [31:0] w);
		w = 32'h0;
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b1;
			w = {w[30:0], line_i};
			#200;
			sclk_o = 1'b0;
			#600;
		end
	endtask

	// A held-high clock requests sync and then power-down.
	task automatic hold(input logic lvl);
		sclk_o = lvl;
	endtask
endmodule

/* File: tb/adc_serial_readout_powerdown_test.sv */
// Self-checking bench for the converter readout and held-clock control.
// Assumes the host model drives the serial clock and CE_I stays high.
`timescale 1ns/1ps
module adc_serial_readout_powerdown_test;
	import adc_readout_pkg::*;
	typedef struct packed {
		logic [23:0] val;
		logic [7:0] n;
	} row_t;
	localparam int PD = 64;
	logic clk, rst_n, ch0, sclk, line;
	logic [23:0] res;
	status_t st;
	int n_fail = 0;
	int compares = 0;
	int t;
	time t0;
	logic [31:0] w, e;
	row_t rows [5] = '{'{24'h000000, 8'h18}, '{24'h800000, 8'h18},
		'{24'h7fffff, 8'h19}, '{24'h3c5a96, 8'h0c}, '{24'h7fffff, 8'h00}};

	adc_readout #(.PD_HOLD(PD)) DUT (.CLK_I(clk), .RST_N_I(rst_n),
		.CE_I(1'b1), .SCLK_I(sclk), .CHANNEL_SELECT_BIT0_I(ch0),
		.CHANNEL_SELECT_BIT1_I(1'b0), .RESULT_I(res),
		.READY_DATA_LINE_O(line), .STATUS_O(st));
	host_reader HR (.sclk_o(sclk), .line_i(line));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Counts falling edges until the line shows lvl, within a limit.
	task automatic wait_line(input logic lvl, input int lim, output int c);
		c = 0;
		while (line !== lvl && c < lim) begin
			@(negedge clk);
			c++;
		end
		if (line !== lvl) begin
			n_fail++;
			$display("Error at %0t: line %h expected %h", $time, line, lvl);
		end
	endtask

	// Waits out any data level, then the low part of a ready pulse; c is its length.
	task automatic ready_pulse(output int c);
		wait_line(1'b1, 400, c);
		wait_line(1'b0, 800, c);
		wait_line(1'b1, 20, c);
	endtask

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Everything should be over in well under 20000 master clocks.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict;
	end

	initial begin
		rst_n = 1'b0;
		ch0 = 1'b0;
		res = rows[0].val;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		// Ordinary reads: the next result is set up after this one is read.
		for (int i = 0; i < 5; i++) begin
			ready_pulse(t);
			chk(32'(t), 32'h6);
			repeat (7) @(negedge clk);
			if (rows[i].n == 8'h00) begin
				for (int k = 0; k < 100; k++) begin
					@(negedge clk);
					chk({31'h0, line}, {31'h0, rows[i].val[23]});
				end
			end else begin
				HR.read_word(int'(rows[i].n), w);
				e = rows[i].n >= 8'h18 ? 32'(rows[i].val) << (rows[i].n - 8'h18)
					: 32'(rows[i].val) >> (8'h18 - rows[i].n);
				chk(w, e);
				if (rows[i].n >= 8'h18)
					chk({31'h0, line}, 32'h0);
			end
			res = (i == 4) ? 24'hffffff : rows[i + 1].val;
			$display("row %0d done", i);
		end
		// A channel change in mid data phase keeps the line high, then restarts.
		ready_pulse(t);
		repeat (20) @(negedge clk);
		ch0 = 1'b1;
		wait_line(1'b0, 2200, t);
		chk({31'h0, t >= 2044 && t <= 2052}, 32'h1);
		$display("channel change done");
		// Held-high clock: sync pulse, modulator reset, then power-down.
		wait_line(1'b1, 20, t);
		HR.hold(1'b1);
		t0 = $time;
		t = 6;
		while (t == 6) begin
			wait_line(1'b0, 500, t);
			wait_line(1'b1, 10, t);
		end
		chk(32'(t), 32'h3);
		repeat (3) @(negedge clk);
		chk({31'h0, (($time - t0) / 100) >= 1537 &&
			(($time - t0) / 100) <= 7679}, 32'h1);
		chk({30'h0, st}, 32'h1);
		repeat (PD - 8) @(negedge clk);
		chk({29'h0, st, line}, 32'h3);
		repeat (12) @(negedge clk);
		chk({29'h0, st, line}, 32'h7);
		$display("power-down done");
		// Wake on the falling serial clock; the cadence then resumes.
		HR.hold(1'b0);
		wait_line(1'b0, 3000, t);
		chk({31'h0, t >= 2319 && t <= 2326}, 32'h1);
		chk({30'h0, st}, 32'h0);
		wait_line(1'b1, 10, t);
		wait_line(1'b0, 400, t);
		chk(32'(t + 6), 32'h180);
		$display("wake done");
		// Held high again but released soon after the pulse: sync only.
		HR.hold(1'b1);
		t = 6;
		while (t == 6) begin
			wait_line(1'b0, 500, t);
			wait_line(1'b1, 10, t);
		end
		chk(32'(t), 32'h3);
		HR.hold(1'b0);
		wait_line(1'b0, 2200, t);
		chk({31'h0, t >= 2044 && t <= 2052}, 32'h1);
		chk({30'h0, st}, 32'h0);
		$display("sync release done");
		print_verdict;
	end
endmodule
